/* verilog/sesm_defines.svh */
// event numbers and widths for the system event source map
// How it works
// R1 - timer 0 low half drives event 67 and timer 1 low half drives event 69.
// R2 - timer 0 high half drives event 68 and timer 1 high half drives event 70.
// R3 - the eight dma completion groups 0 to 7 drive events 71 to 78 in order.
// R4 - event 96 tells that the controller dropped a cpu interrupt event.
// R5 - event 97 rises when invalid internal dma parameters are detected.
// R6 - external interface side a drives event 100 and side b drives event 101.
// R7 - event 113 rises on a program memory single-bit error during a dma read.
// R8 - event 116 rises on every level-two single-bit error.
// R9 - event 117 rises on every level-two two-bit error.
// R10 - cpu protection faults drive 120, 122, 124 and 126 (prog, data, level2, int dma).
// R11 - dma protection faults drive 121, 123 and 125 (prog, data, level2).
// R12 - event 127 rises on an internal dma bus error.
// R13 - reserved events are never asserted and software must not use them.
// R14 - the controller takes up to 128 events, each routable to any cpu input.
// R15 - events 0 to 3 carry combiners of events 1-31, 32-63, 64-95 and 96-127.
// R16 - pin events 8 to 15 drive events 59 to 66 in order.
// R17 - each source reaches the controller as a one-cycle pulse on the cpu clock.
`ifndef SESM_DEFINES_SVH
`define SESM_DEFINES_SVH
`define SESM_NUM_EVENTS 128
`define SESM_EV_PIN8 59
`define SESM_EV_T0_LO 67
`define SESM_EV_T0_HI 68
`define SESM_EV_T1_LO 69
`define SESM_EV_T1_HI 70
`define SESM_EV_DMA0 71
`define SESM_EV_DROPPED 96
`define SESM_EV_IDMA_PARAM 97
`define SESM_EV_EXT_A 100
`define SESM_EV_EXT_B 101
`define SESM_EV_PROG_SBE 113
`define SESM_EV_L2_SBE 116
`define SESM_EV_L2_DBE 117
`define SESM_EV_PROG_CPU_PF 120
`define SESM_EV_PROG_DMA_PF 121
`define SESM_EV_DATA_CPU_PF 122
`define SESM_EV_DATA_DMA_PF 123
`define SESM_EV_L2_CPU_PF 124
`define SESM_EV_L2_DMA_PF 125
`define SESM_EV_IDMA_CPU_PF 126
`define SESM_EV_IDMA_BUS 127
`define SESM_NUM_PIN 8
`define SESM_NUM_DMA 8
`define SESM_NUM_COMB 4
`define SESM_COMB_W 32
`endif

/* verilog/sesm_pkg.sv */
// types shared by the system event source map
`default_nettype none
package sesm_pkg;
   typedef logic [127:0] sesm_vec_t;
endpackage
`default_nettype wire

/* verilog/sesm_pulse.sv */
// rising-edge to single-cycle pulse converter for one event source
`timescale 1ns/10ps
`default_nettype none
module sesm_pulse (
   input wire logic clk,
   input wire logic rst,
   input wire logic level_in,
   output logic pulse_out
);
   logic prev_r;
   logic prev_nxt;
   logic pulse_r;
   logic pulse_nxt;

   // a held level yields only one event, so a slow source cannot flood the controller
   always_comb begin
      prev_nxt = level_in;
      pulse_nxt = level_in & ~prev_r; // R17
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         prev_r <= 1'b0;
         pulse_r <= 1'b0;
      end else begin
         prev_r <= prev_nxt;
         pulse_r <= pulse_nxt;
      end
   end

   assign pulse_out = pulse_r;
endmodule
`default_nettype wire

/* verilog/sesm_combiner.sv */
// event combiner: or of a group of events, one registered output
`timescale 1ns/10ps
`default_nettype none
module sesm_combiner #(
   parameter int W = 32
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] events_in,
   output logic combined_out
);
   logic comb_r;
   logic comb_nxt;

   // any event of the group fires the combined event
   always_comb begin
      comb_nxt = |events_in; // R15
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         comb_r <= 1'b0;
      end else begin
         comb_r <= comb_nxt;
      end
   end

   assign combined_out = comb_r;
endmodule
`default_nettype wire

/* verilog/sesm_map.sv */
// system event source map: sources onto the 128-input event vector
`timescale 1ns/10ps
`default_nettype none
`include "sesm_defines.svh"
module sesm_map (
   input wire logic CLOCK,
   input wire logic RESET,
   input wire logic [7:0] PIN_EVENT,
   input wire logic TIMER0_LOW_EVENT,
   input wire logic TIMER0_HIGH_EVENT,
   input wire logic TIMER1_LOW_EVENT,
   input wire logic TIMER1_HIGH_EVENT,
   input wire logic [7:0] DMA_DONE_GROUP,
   input wire logic EVENT_DROPPED,
   input wire logic INTERNAL_DMA_PARAM_FAULT,
   input wire logic EXT_IF_EVENT_A,
   input wire logic EXT_IF_EVENT_B,
   input wire logic PROG_MEM_SINGLE_ERR,
   input wire logic LEVEL2_SINGLE_ERR,
   input wire logic LEVEL2_DOUBLE_ERR,
   input wire logic PROG_MEM_CPU_PROT_FAULT,
   input wire logic PROG_MEM_DMA_PROT_FAULT,
   input wire logic DATA_MEM_CPU_PROT_FAULT,
   input wire logic DATA_MEM_DMA_PROT_FAULT,
   input wire logic LEVEL2_CPU_PROT_FAULT,
   input wire logic LEVEL2_DMA_PROT_FAULT,
   input wire logic INTERNAL_DMA_CPU_PROT_FAULT,
   input wire logic INTERNAL_DMA_BUS_FAULT,
   output logic [127:0] SYSTEM_EVENTS
);
   localparam int NSRC = 35;
   logic [NSRC-1:0] src_level;
   logic [NSRC-1:0] src_pulse;
   logic [3:0] comb_out;
   sesm_pkg::sesm_vec_t ev_raw;

   // gather every source level in one vector, pin and dma groups first
   assign src_level = {INTERNAL_DMA_BUS_FAULT, INTERNAL_DMA_CPU_PROT_FAULT,
      LEVEL2_DMA_PROT_FAULT, LEVEL2_CPU_PROT_FAULT, DATA_MEM_DMA_PROT_FAULT,
      DATA_MEM_CPU_PROT_FAULT, PROG_MEM_DMA_PROT_FAULT, PROG_MEM_CPU_PROT_FAULT,
      LEVEL2_DOUBLE_ERR, LEVEL2_SINGLE_ERR, PROG_MEM_SINGLE_ERR,
      EXT_IF_EVENT_B, EXT_IF_EVENT_A, INTERNAL_DMA_PARAM_FAULT, EVENT_DROPPED,
      TIMER1_HIGH_EVENT, TIMER1_LOW_EVENT, TIMER0_HIGH_EVENT, TIMER0_LOW_EVENT,
      DMA_DONE_GROUP, PIN_EVENT};

   // one edge-to-pulse stage per source
   genvar g;
   generate
      for (g = 0; g < NSRC; g++) begin : g_src
         sesm_pulse u_pulse (
            .clk(CLOCK),
            .rst(RESET),
            .level_in(src_level[g]),
            .pulse_out(src_pulse[g])
         );
      end
   endgenerate

   // place each pulse at its event number; unlisted and reserved slots stay zero
   always_comb begin
      ev_raw = '0; // R13
      for (int i = 0; i < `SESM_NUM_PIN; i++) begin
         ev_raw[`SESM_EV_PIN8 + i] = src_pulse[i]; // R16
      end
      for (int i = 0; i < `SESM_NUM_DMA; i++) begin
         ev_raw[`SESM_EV_DMA0 + i] = src_pulse[8 + i]; // R3
      end
      ev_raw[`SESM_EV_T0_LO] = src_pulse[16]; // R1
      ev_raw[`SESM_EV_T0_HI] = src_pulse[17]; // R2
      ev_raw[`SESM_EV_T1_LO] = src_pulse[18]; // R1
      ev_raw[`SESM_EV_T1_HI] = src_pulse[19]; // R2
      ev_raw[`SESM_EV_DROPPED] = src_pulse[20]; // R4
      ev_raw[`SESM_EV_IDMA_PARAM] = src_pulse[21]; // R5
      ev_raw[`SESM_EV_EXT_A] = src_pulse[22]; // R6
      ev_raw[`SESM_EV_EXT_B] = src_pulse[23]; // R6
      ev_raw[`SESM_EV_PROG_SBE] = src_pulse[24]; // R7
      ev_raw[`SESM_EV_L2_SBE] = src_pulse[25]; // R8
      ev_raw[`SESM_EV_L2_DBE] = src_pulse[26]; // R9
      ev_raw[`SESM_EV_PROG_CPU_PF] = src_pulse[27]; // R10
      ev_raw[`SESM_EV_PROG_DMA_PF] = src_pulse[28]; // R11
      ev_raw[`SESM_EV_DATA_CPU_PF] = src_pulse[29]; // R10
      ev_raw[`SESM_EV_DATA_DMA_PF] = src_pulse[30]; // R11
      ev_raw[`SESM_EV_L2_CPU_PF] = src_pulse[31]; // R10
      ev_raw[`SESM_EV_L2_DMA_PF] = src_pulse[32]; // R11
      ev_raw[`SESM_EV_IDMA_CPU_PF] = src_pulse[33]; // R10
      ev_raw[`SESM_EV_IDMA_BUS] = src_pulse[34]; // R12
   end

   // combiners see the same pulses; their outputs lag the raw events by one cycle
   generate
      for (g = 0; g < `SESM_NUM_COMB; g++) begin : g_comb
         sesm_combiner #(.W(`SESM_COMB_W)) u_comb (
            .clk(CLOCK),
            .rst(RESET),
            .events_in(g == 0 ? {ev_raw[31:1], 1'b0} : ev_raw[g*32 +: 32]), // R15
            .combined_out(comb_out[g])
         );
      end
   endgenerate

   // full 128-wide vector toward the controller, slots 0-3 from the combiners
   assign SYSTEM_EVENTS = {ev_raw[127:4], comb_out}; // R14
endmodule
`default_nettype wire

/* verification/sesm_monitor.sv */
// assertion checker bound to the system event source map
`timescale 1ns/10ps
`default_nettype none
module sesm_monitor (
   input wire logic CLOCK,
   input wire logic RESET,
   input wire logic [7:0] PIN_EVENT,
   input wire logic TIMER0_LOW_EVENT,
   input wire logic TIMER1_HIGH_EVENT,
   input wire logic [7:0] DMA_DONE_GROUP,
   input wire logic LEVEL2_DOUBLE_ERR,
   input wire logic INTERNAL_DMA_BUS_FAULT,
   input wire logic [127:0] SYSTEM_EVENTS
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RESET);
   // a rising source pulses its own bit for exactly one cycle
   sequence s_bus_rise; $rose(INTERNAL_DMA_BUS_FAULT); endsequence
   sequence s_one_pulse; SYSTEM_EVENTS[127] ##1 !SYSTEM_EVENTS[127]; endsequence
   a_pin_first: assert property ($rose(PIN_EVENT[0]) |=> SYSTEM_EVENTS[59])
      else $error("pin event lost");
   a_timer_low: assert property ($rose(TIMER0_LOW_EVENT) |=> SYSTEM_EVENTS[67])
      else $error("timer low lost");
   a_timer_high: assert property ($rose(TIMER1_HIGH_EVENT) |=> SYSTEM_EVENTS[70])
      else $error("timer high lost");
   a_dma_last: assert property ($rose(DMA_DONE_GROUP[7]) |=> SYSTEM_EVENTS[78])
      else $error("dma group lost");
   a_double_err: assert property ($rose(LEVEL2_DOUBLE_ERR) |=> SYSTEM_EVENTS[117])
      else $error("double error lost");
   a_bus_pulse: assert property (s_bus_rise |=> s_one_pulse)
      else $error("bus fault pulse wrong");
   a_top_combiner: assert property (SYSTEM_EVENTS[127] |=> SYSTEM_EVENTS[3])
      else $error("combiner 3 missed");
   a_reserved_zero: assert property (SYSTEM_EVENTS[95:85] == '0 && !SYSTEM_EVENTS[80]
      && SYSTEM_EVENTS[112:102] == '0 && SYSTEM_EVENTS[99:98] == '0
      && SYSTEM_EVENTS[115:114] == '0 && !SYSTEM_EVENTS[119])
      else $error("reserved event raised");
endmodule
bind sesm_map sesm_monitor i_mon (.CLOCK, .RESET, .PIN_EVENT, .TIMER0_LOW_EVENT,
   .TIMER1_HIGH_EVENT, .DMA_DONE_GROUP, .LEVEL2_DOUBLE_ERR, .INTERNAL_DMA_BUS_FAULT,
   .SYSTEM_EVENTS);
`default_nettype wire

/* verification/sesm_ctrl_model.sv */
// event controller stand-in that tallies the pulses offered to it
`timescale 1ns/10ps
`default_nettype none
module sesm_ctrl_model (
   input wire logic CLOCK,
   input wire logic RESET,
   input wire logic [127:0] SYSTEM_EVENTS,
   output int PULSES
);
   // combiner bits 0 to 3 left out so each source counts once
   always_ff @(posedge CLOCK) begin
      if (RESET) PULSES <= 0;
      else PULSES <= PULSES + $countones(SYSTEM_EVENTS[127:4]);
   end
endmodule
`default_nettype wire

/* verification/system_event_source_map_tb.sv */
// self-checking bench for the system event source map
`timescale 1ns/10ps
`default_nettype none
module system_event_source_map_tb;
   logic CLOCK = 1'b0;
   logic RESET = 1'b1;
   logic [34:0] s = '0;
   logic [127:0] ev;
   int n_fail = 0;
   int comparisons = 0;
   int seen;
   int row_ev [35];
   int hi [15] = '{96, 97, 100, 101, 113, 116, 117, 120, 121, 122, 123, 124, 125, 126, 127};
   sesm_map i_dut (.CLOCK, .RESET, .PIN_EVENT(s[7:0]), .TIMER0_LOW_EVENT(s[8]),
      .TIMER0_HIGH_EVENT(s[9]), .TIMER1_LOW_EVENT(s[10]), .TIMER1_HIGH_EVENT(s[11]),
      .DMA_DONE_GROUP(s[19:12]), .EVENT_DROPPED(s[20]), .INTERNAL_DMA_PARAM_FAULT(s[21]),
      .EXT_IF_EVENT_A(s[22]), .EXT_IF_EVENT_B(s[23]), .PROG_MEM_SINGLE_ERR(s[24]),
      .LEVEL2_SINGLE_ERR(s[25]), .LEVEL2_DOUBLE_ERR(s[26]), .PROG_MEM_CPU_PROT_FAULT(s[27]),
      .PROG_MEM_DMA_PROT_FAULT(s[28]), .DATA_MEM_CPU_PROT_FAULT(s[29]),
      .DATA_MEM_DMA_PROT_FAULT(s[30]), .LEVEL2_CPU_PROT_FAULT(s[31]),
      .LEVEL2_DMA_PROT_FAULT(s[32]), .INTERNAL_DMA_CPU_PROT_FAULT(s[33]),
      .INTERNAL_DMA_BUS_FAULT(s[34]), .SYSTEM_EVENTS(ev));
   sesm_ctrl_model i_ctrl (.CLOCK, .RESET, .SYSTEM_EVENTS(ev), .PULSES(seen));
   // 25 MHz clock
   always #20 CLOCK = ~CLOCK;
   task automatic chk(input logic [127:0] got, input logic [127:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h", $time, got);
      end
   endtask
   task automatic give_verdict();
      $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // rows: source bit i in, event row_ev[i] out
   initial begin
      logic [127:0] e;
      int k;
      for (int i = 0; i < 35; i++) row_ev[i] = (i < 20) ? 59 + i : hi[i - 20];
      repeat (4) @(posedge CLOCK);
      RESET <= 1'b0;
      for (int i = 0; i < 35; i++) begin
         @(posedge CLOCK) s <= 35'h1 << i;
         @(posedge CLOCK) #1;
         e = '0;
         e[row_ev[i]] = 1'b1;
         chk({ev[127:4], 4'h0}, e);
         @(posedge CLOCK) #1;
         e = '0;
         e[row_ev[i] / 32] = 1'b1;
         chk(ev, e);
         @(posedge CLOCK) s <= '0;
      end
      chk(128'(seen), 128'h23);
      // a source toggling every cycle retriggers every second cycle
      k = 0;
      for (int c = 0; c < 8; c++) begin
         @(posedge CLOCK) s[8] <= ~s[8];
         #1 k += int'(ev[67]);
      end
      chk(128'(k), 128'h4);
      // all sources at once: every mapped bit, reserved bits quiet
      @(posedge CLOCK) s <= '1;
      @(posedge CLOCK) #1;
      e = '0;
      for (int i = 0; i < 35; i++) e[row_ev[i]] = 1'b1;
      chk({ev[127:4], 4'h0}, e);
      // reset in mid-run clears the vector at the next clock edge
      @(posedge CLOCK) RESET <= 1'b1;
      @(posedge CLOCK) #1 chk(ev, '0);
      // release with every source still high: the held level counts as one fresh rise
      @(posedge CLOCK) RESET <= 1'b0;
      #1 chk(ev, '0);
      @(posedge CLOCK) #1;
      chk({ev[127:4], 4'h0}, e);
      // the level stays high, so only the combiners show the group one cycle later
      @(posedge CLOCK) #1;
      chk(ev, 128'h0e);
      give_verdict();
   end
endmodule
`default_nettype wire
